// ---- design/t16ba_timer.sv ----
// 16-bit up-counter with prescaler, external/crystal clock input,
// trigger reset, overflow flag and optional buffered 16-bit access.
// assumes an Avalon-MM master on i_core_clk and a crystal/pin input
// that is slow compared to the 40 MHz core clock.
// compare unit and converter signals share the core clock and are used
// without synchronisers.
//
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

module t16ba_timer (
    input wire logic i_core_clk,                    // core clock, 40 MHz
    input wire logic i_sys_rst,                     // sync reset, high
    input wire logic [3:0] i_avs_address,           // byte address
    input wire logic i_avs_read,                    // read request
    input wire logic i_avs_write,                   // write request
    input wire logic [31:0] i_avs_writedata,        // write data
    input wire logic [3:0] i_avs_byteenable,        // byte lanes
    output logic [31:0] o_avs_readdata,             // read data
    output logic o_avs_waitrequest,                 // stall
    output logic o_avs_readdatavalid_unused,        // tied low, no pipeline
    input wire logic i_external_clock_pin,          // async clock pin
    input wire logic i_crystal_clock,               // crystal amp output
    input wire logic i_sleep,                       // device in sleep
    input wire logic [3:0] i_compare_unit_mode_field, // compare mode
    input wire logic i_compare_match,               // compare event
    input wire logic i_adc_enabled,                 // converter enabled
    output logic o_adc_start,                       // conversion request
    output logic o_crystal_osc_run,                 // oscillator enable
    output logic o_crystal_pins_input,              // pins forced input
    output logic o_overflow_irq                     // interrupt request
);
    import t16ba_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    // software-visible registers
    t16ba_control_t control;
    logic [15:0] count;
    logic [7:0] high_buffer;
    logic overflow_flag;
    logic overflow_irq_enable;
    // clock path and prescaler
    logic [2:0] prescale;
    logic [1:0] instr_div;
    logic pin_meta;
    logic pin_q;
    logic xtal_meta;
    logic xtal_q;
    logic [2:0] ext_sync;
    logic ext_raw_q;
    // bus handshake and read path
    logic wait_done;
    logic [31:0] readdata;
    t16ba_req_t req;
    // per-cycle strobes and the selected external level
    logic next_tick;
    logic prescaled_tick;
    logic trigger;
    logic wr_low;
    logic wr_high;
    logic rd_low;
    logic count_wrap;
    logic ext_level;

    // ****************************************************************
    // bus access: one wait state so every access has a single edge
    // ****************************************************************
    // the first cycle of a request stalls; the second completes it. a
    // read acts on the first edge, a write on the second, so each side
    // effect fires exactly once per request.
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            wait_done <= 1'b0;
        end else begin
            wait_done <= (i_avs_read | i_avs_write) & ~wait_done;
        end
    end

    // combinational, so the stall rises together with the request
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~wait_done;
    assign o_avs_readdatavalid_unused = 1'b0;

    // decoded request: a read acts on its capture edge (the first one),
    // so the low byte and the buffered high byte come from one count;
    // a write acts on the completing edge
    always_comb begin
        req.rd = i_avs_read & ~wait_done;
        req.wr = i_avs_write & wait_done & i_avs_byteenable[0];
        req.addr = i_avs_address;
        req.data = i_avs_writedata[7:0];
    end

    // register strobes, one per count-byte access that has a side effect
    assign wr_low = req.wr & (req.addr == T16BA_OFS_LOW);
    assign wr_high = req.wr & (req.addr == T16BA_OFS_HIGH);
    assign rd_low = req.rd & (req.addr == T16BA_OFS_LOW);

    // ****************************************************************
    // control register
    // ****************************************************************
    // bit 6 is never stored, so it reads back zero
    // a write replaces every stored bit at once; there is no partial merge
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            control <= T16BA_CONTROL_RST;
        end else if (req.wr & (req.addr == T16BA_OFS_CONTROL)) begin
            control <= req.data & T16BA_CONTROL_MASK;
        end
    end

    // the oscillator runs through sleep; sleep is not looked at here
    // both crystal pins turn to inputs while the oscillator is enabled
    assign o_crystal_osc_run = control.crystal_osc_enable;
    assign o_crystal_pins_input = control.crystal_osc_enable;

    // ****************************************************************
    // clock source selection
    // ****************************************************************
    // each source has its own two-flop synchroniser ahead of the select
    // mux; muxing raw pins first would let a metastable level reach logic
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            pin_meta <= 1'b0;
            pin_q <= 1'b0;
            xtal_meta <= 1'b0;
            xtal_q <= 1'b0;
        end else begin
            pin_meta <= i_external_clock_pin;
            pin_q <= pin_meta;
            xtal_meta <= i_crystal_clock;
            xtal_q <= xtal_meta;
        end
    end

    // pin or crystal, chosen by the oscillator enable bit
    assign ext_level = control.crystal_osc_enable ? xtal_q : pin_q;

    // alignment stages behind the synchronisers; the last two find the
    // rising edge in the synchronised counter mode
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            ext_sync <= 3'h0;
        end else begin
            ext_sync <= {ext_sync[1:0], ext_level};
        end
    end

    // the unsynchronised path still has to land in the core domain; it
    // skips the edge-alignment stages, so it reacts two cycles sooner,
    // but a trigger reset may then race the count
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            ext_raw_q <= 1'b0;
        end else begin
            ext_raw_q <= ext_level;
        end
    end

    // instruction cycle is one core clock in four; the divider runs free,
    // so the first tick after a start may come up to three cycles late,
    // a skew software has to allow for when timing short spans
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            instr_div <= 2'h0;
        end else begin
            instr_div <= instr_div + 2'h1;
        end
    end

    // tick source: the instruction cycle, or a rising edge of the chosen
    // external level, aligned (synced mode) or straight (raw mode)
    always_comb begin
        if (!control.clock_source_select) begin
            next_tick = (instr_div == T16BA_INSTR_DIV_LAST);
        end else if (control.ext_clock_sync_disable) begin
            next_tick = ext_level & ~ext_raw_q;
        end else begin
            next_tick = ext_sync[1] & ~ext_sync[2];
        end
    end

    // ****************************************************************
    // prescaler
    // ****************************************************************
    // counts qualified ticks only; a low-byte write restarts it so that
    // a freshly loaded count gets a full prescale period, while a
    // high-byte write leaves it alone
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            prescale <= T16BA_PRESCALE_RST;
        end else if (wr_low) begin
            prescale <= T16BA_PRESCALE_RST;
        end else if (next_tick & control.counter_on) begin
            prescale <= prescale + 3'h1;
        end
    end

    // every tick, or one tick in 2, 4 or 8, passes, on the last count of each group
    always_comb begin
        unique case (control.input_prescale_select)
            2'h0: prescaled_tick = next_tick;
            2'h1: prescaled_tick = next_tick & (prescale[0] == 1'b1);
            2'h2: prescaled_tick = next_tick & (prescale[1:0] == 2'h3);
            2'h3: prescaled_tick = next_tick & (prescale == 3'h7);
        endcase
    end

    // ****************************************************************
    // counter
    // ****************************************************************
    // special event trigger from the compare unit; it acts only in the
    // mode that selects it. in unsynchronised counter mode it may race
    // the external edge, a limitation the user has to live with
    assign trigger = i_compare_match &
                     (i_compare_unit_mode_field == T16BA_TRIGGER_MODE);
    assign count_wrap = control.counter_on & prescaled_tick &
                        (count == T16BA_COUNT_MAX);

    // software writes come first so they beat the trigger reset
    // a narrow high-byte write lands only while wide access is off; in
    // wide mode the same address reaches the buffer instead
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            count <= T16BA_COUNT_RST;
        end else if (wr_low & control.wide_access_enable) begin
            count <= {high_buffer, req.data};
        end else if (wr_low) begin
            count[7:0] <= req.data;
        end else if (wr_high & ~control.wide_access_enable) begin
            count[15:8] <= req.data;
        end else if (trigger) begin
            count <= T16BA_COUNT_RST;
        end else if (control.counter_on & prescaled_tick) begin
            count <= count + 16'h0001;
        end
    end

    // conversion start follows the trigger when the converter is on
    // registered so the converter sees a clean pulse, high one cycle for each trigger cycle
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_adc_start <= 1'b0;
        end else begin
            o_adc_start <= trigger & i_adc_enabled;
        end
    end

    // ****************************************************************
    // high byte buffer
    // ****************************************************************
    // in wide mode the high address reaches only this buffer: a write
    // parks the byte until the next low write, and a low-byte read
    // refreshes it from the live count on the capture edge
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            high_buffer <= 8'h00;
        end else if (wr_high & control.wide_access_enable) begin
            high_buffer <= req.data;
        end else if (rd_low & control.wide_access_enable) begin
            high_buffer <= count[15:8];
        end
    end

    // ****************************************************************
    // overflow flag and enable
    // ****************************************************************
    // a wrap in the clearing cycle wins; trigger never sets it
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            overflow_flag <= 1'b0;
        end else if (count_wrap & ~trigger & ~wr_low) begin
            overflow_flag <= 1'b1;
        end else if (req.wr & (req.addr == T16BA_OFS_IRQ) &
                     ~req.data[T16BA_BIT_IRQ_FLAG]) begin
            overflow_flag <= 1'b0;
        end
    end

    // interrupt enable, bit 1 of the flag register; every write loads it from data bit 1
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            overflow_irq_enable <= 1'b0;
        end else if (req.wr & (req.addr == T16BA_OFS_IRQ)) begin
            overflow_irq_enable <= req.data[T16BA_BIT_IRQ_EN];
        end
    end

    // the flag still latches while masked, so enabling later raises it
    assign o_overflow_irq = overflow_flag & overflow_irq_enable;

    // ****************************************************************
    // read data
    // ****************************************************************
    // read mux; unmapped addresses return zero and the upper lanes are
    // always zero, since every register is one byte wide
    always_comb begin
        readdata = 32'h0000_0000;
        unique case (req.addr)
            T16BA_OFS_CONTROL: readdata[7:0] = control;
            T16BA_OFS_LOW: readdata[7:0] = count[7:0];
            T16BA_OFS_HIGH: readdata[7:0] = control.wide_access_enable ?
                                            high_buffer : count[15:8];
            T16BA_OFS_IRQ: readdata[1:0] = {overflow_irq_enable,
                                            overflow_flag};
            default: readdata = 32'h0000_0000;
        endcase
    end

    // registered so data stands at the completing edge
    // held until the next read, so a late sample still finds it
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (req.rd) begin
            o_avs_readdata <= readdata;
        end
    end

endmodule : t16ba_timer

`default_nettype wire

// ---- shared/t16ba_pkg.sv ----
// package for the 16-bit buffered-access timer: register map, field
// positions, reset values and the packed carriers shared by the design.
// assumes a 32-bit Avalon-MM register bus with word-aligned registers.
package t16ba_pkg;

    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam logic [3:0] T16BA_OFS_CONTROL = 4'h0;
    localparam logic [3:0] T16BA_OFS_LOW = 4'h4;
    localparam logic [3:0] T16BA_OFS_HIGH = 4'h8;
    localparam logic [3:0] T16BA_OFS_IRQ = 4'hC;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int T16BA_BIT_WIDE = 7;
    localparam int T16BA_BIT_PS_HI = 5;
    localparam int T16BA_BIT_PS_LO = 4;
    localparam int T16BA_BIT_OSC = 3;
    localparam int T16BA_BIT_NOSYNC = 2;
    localparam int T16BA_BIT_CS = 1;
    localparam int T16BA_BIT_ON = 0;
    localparam int T16BA_BIT_IRQ_FLAG = 0;
    localparam int T16BA_BIT_IRQ_EN = 1;

    // ****************************************************************
    // reset values and constants
    // ****************************************************************
    localparam logic [7:0] T16BA_CONTROL_RST = 8'h00;
    localparam logic [7:0] T16BA_CONTROL_MASK = 8'hBF;
    localparam logic [15:0] T16BA_COUNT_RST = 16'h0000;
    localparam logic [15:0] T16BA_COUNT_MAX = 16'hFFFF;
    localparam logic [2:0] T16BA_PRESCALE_RST = 3'h0;
    localparam logic [1:0] T16BA_INSTR_DIV_LAST = 2'h3;
    localparam logic [3:0] T16BA_TRIGGER_MODE = 4'hB;

    // decoded control register contents
    typedef struct packed {
        logic wide_access_enable;
        logic unused_bit6;
        logic [1:0] input_prescale_select;
        logic crystal_osc_enable;
        logic ext_clock_sync_disable;
        logic clock_source_select;
        logic counter_on;
    } t16ba_control_t;

    // one bus request as seen by the register file
    typedef struct packed {
        logic rd;
        logic wr;
        logic [3:0] addr;
        logic [7:0] data;
    } t16ba_req_t;

endpackage : t16ba_pkg

// ---- test/t16ba_asserts.sv ----
// checker for the buffered 16-bit timer: bus wait state, trigger, pins
// sees only the ports of t16ba_timer; bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module t16ba_asserts (
    input wire logic i_core_clk,               // core clock
    input wire logic i_sys_rst,                // sync reset, high
    input wire logic [3:0] i_avs_address,      // byte address
    input wire logic i_avs_read,               // read request
    input wire logic i_avs_write,              // write request
    input wire logic [31:0] o_avs_readdata,    // read data
    input wire logic o_avs_waitrequest,        // stall
    input wire logic o_avs_readdatavalid_unused, // tied low
    input wire logic [3:0] i_compare_unit_mode_field, // compare mode
    input wire logic i_compare_match,          // compare event
    input wire logic i_adc_enabled,            // converter enabled
    input wire logic o_adc_start,              // conversion request
    input wire logic o_crystal_osc_run,        // oscillator enable
    input wire logic o_crystal_pins_input      // pins forced input
);
    logic trig_q;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_start;
        $rose(i_avs_read || i_avs_write);
    endsequence
    sequence s_trig;
        i_compare_unit_mode_field == 4'hB && i_compare_match;
    endsequence
    // remember a qualified trigger so a stray start pulse is caught
    always_ff @(posedge i_core_clk) begin
        trig_q <= !i_sys_rst && i_adc_enabled && i_compare_match &&
            i_compare_unit_mode_field == 4'hB;
    end
    AST_WAIT_FIRST: assert property (s_start |-> o_avs_waitrequest
        ##1 !o_avs_waitrequest) else $error("wait state not exactly one");
    AST_IDLE_NOWAIT: assert property (!(i_avs_read || i_avs_write)
        |-> !o_avs_waitrequest) else $error("wait while idle");
    AST_UPPER_ZERO: assert property (o_avs_readdata[31:8] == 24'h0 &&
        !o_avs_readdatavalid_unused) else $error("upper read bits set");
    AST_BIT6_ZERO: assert property (i_avs_read && !o_avs_waitrequest &&
        i_avs_address == 4'h0 |-> !o_avs_readdata[6])
        else $error("control bit 6 read as one");
    AST_ADC_START: assert property (s_trig ##0 i_adc_enabled
        |=> o_adc_start) else $error("conversion not requested");
    AST_ADC_CAUSE: assert property (o_adc_start |-> trig_q)
        else $error("conversion request without trigger");
    AST_OSC_PINS: assert property (o_crystal_osc_run ==
        o_crystal_pins_input) else $error("pins not forced with osc");
    AST_RST_CLEAR: assert property ($fell(i_sys_rst) |->
        !o_crystal_osc_run && !o_adc_start && o_avs_readdata == 32'h0)
        else $error("state not cleared by reset");
endmodule : t16ba_asserts
bind t16ba_timer t16ba_asserts u_chk (.i_core_clk, .i_sys_rst,
    .i_avs_address, .i_avs_read, .i_avs_write, .o_avs_readdata,
    .o_avs_waitrequest, .o_avs_readdatavalid_unused,
    .i_compare_unit_mode_field, .i_compare_match, .i_adc_enabled,
    .o_adc_start, .o_crystal_osc_run, .o_crystal_pins_input);
`default_nettype wire

// ---- test/t16ba_ext_src.sv ----
// model of the far side: external clock pin source and 1 MHz crystal
// assumes the bench opens pin bursts; the crystal follows the amplifier
`timescale 1ns/1ps
`default_nettype none
module t16ba_ext_src (
    input wire logic i_pin_run,       // bench opens a pin burst
    input wire logic i_xtal_run,      // amplifier enabled by device
    output logic o_pin,               // external clock pin
    output logic o_xtal,              // crystal clock
    output logic [15:0] o_pin_edges   // rising edges in this burst
);
    initial begin
        o_pin = 1'b0;
        o_xtal = 1'b0;
        o_pin_edges = 16'h0;
    end
    // pin rests low between bursts; a started pulse always completes
    always begin
        @(posedge i_pin_run);
        o_pin_edges = 16'h0;
        while (i_pin_run) begin
            #200 o_pin = 1'b1;
            o_pin_edges = o_pin_edges + 16'h1;
            #200 o_pin = 1'b0;
        end
    end
    // crystal swings only while powered; sleep does not stop it
    always begin
        wait (i_xtal_run === 1'b1);
        #500 o_xtal = 1'b1;
        #500 o_xtal = 1'b0;
    end
endmodule : t16ba_ext_src
`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench for the buffered 16-bit timer over Avalon-MM
// assumes registers on word addresses; waits for waitrequest low
`timescale 1ns/1ps
`default_nettype none
module tb;
    import t16ba_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat;
    logic [3:0] mode = 4'h0;
    logic slp = 1'b0;
    logic match = 1'b0;
    logic adce = 1'b0;
    logic pin_run = 1'b0;
    logic pin, xtal, adcs, oscr, pinsin, irq, wreq;
    logic [15:0] edges;
    logic [7:0] q;
    logic [7:0] codes [3] = '{8'h03, 8'h07, 8'h0B};
    int err_count = 0;
    int checks_done = 0;
    always #12.5 i_core_clk = ~i_core_clk;
    t16ba_timer u_dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .i_avs_byteenable(4'hF),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
        .o_avs_readdatavalid_unused(), .i_external_clock_pin(pin),
        .i_crystal_clock(xtal), .i_sleep(slp),
        .i_compare_unit_mode_field(mode), .i_compare_match(match),
        .i_adc_enabled(adce), .o_adc_start(adcs),
        .o_crystal_osc_run(oscr), .o_crystal_pins_input(pinsin),
        .o_overflow_irq(irq));
    t16ba_ext_src u_src (.i_pin_run(pin_run), .i_xtal_run(oscr),
        .o_pin(pin), .o_xtal(xtal), .o_pin_edges(edges));
    task automatic tick(input int n);
        repeat (n) @(posedge i_core_clk);
    endtask : tick
    task check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one access held until waitrequest is seen low at a rising edge;
    // read data is taken at that edge, then one idle edge follows
    task bus(input logic r, input logic [3:0] a, input logic [7:0] d);
        rd <= r;
        wr <= !r;
        adr <= a;
        wd <= {24'h0, d};
        @(posedge i_core_clk);
        while (wreq !== 1'b0) begin
            @(posedge i_core_clk);
        end
        q = rdat[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge i_core_clk);
    endtask : bus
    task rdchk(input logic [3:0] a, input logic [7:0] e);
        bus(1'b1, a, 8'h0);
        check({8'h0, q}, {8'h0, e});
    endtask : rdchk
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    // the whole run is under two thousand cycles; this bound cuts a hang
    initial begin
        tick(20000);
        err_count++;
        tally_and_finish();
    end
    initial begin
        tick(3);
        i_sys_rst <= 1'b0;
        tick(1);
        rdchk(T16BA_OFS_CONTROL, 8'h00);
        rdchk(T16BA_OFS_HIGH, 8'h00);
        bus(1'b0, T16BA_OFS_CONTROL, 8'h7C);
        rdchk(T16BA_OFS_CONTROL, 8'h3C);
        check({15'h0, pinsin}, 16'h1);
        bus(1'b0, T16BA_OFS_CONTROL, 8'h00);
        check({15'h0, oscr}, 16'h0);
        rdchk(4'h1, 8'h00);
        $display("test control done");
        bus(1'b0, T16BA_OFS_LOW, 8'h34);
        bus(1'b0, T16BA_OFS_HIGH, 8'h12);
        rdchk(T16BA_OFS_HIGH, 8'h12);
        bus(1'b0, T16BA_OFS_CONTROL, 8'h80);
        bus(1'b0, T16BA_OFS_HIGH, 8'hAB);
        rdchk(T16BA_OFS_HIGH, 8'hAB);
        bus(1'b0, T16BA_OFS_CONTROL, 8'h00);
        rdchk(T16BA_OFS_HIGH, 8'h12);
        bus(1'b0, T16BA_OFS_CONTROL, 8'h80);
        bus(1'b0, T16BA_OFS_LOW, 8'hCD);
        bus(1'b0, T16BA_OFS_CONTROL, 8'h00);
        rdchk(T16BA_OFS_HIGH, 8'hAB);
        rdchk(T16BA_OFS_LOW, 8'hCD);
        bus(1'b0, T16BA_OFS_HIGH, 8'h56);
        bus(1'b0, T16BA_OFS_CONTROL, 8'h80);
        rdchk(T16BA_OFS_LOW, 8'hCD);
        rdchk(T16BA_OFS_HIGH, 8'h56);
        bus(1'b0, T16BA_OFS_CONTROL, 8'h00);
        $display("test access done");
        // eight ticks per window at every divide; stopped count must hold
        for (int p = 0; p < 4; p++) begin
            bus(1'b0, T16BA_OFS_HIGH, 8'h00);
            bus(1'b0, T16BA_OFS_LOW, 8'h00);
            bus(1'b0, T16BA_OFS_CONTROL, {2'b00, p[1:0], 4'h1});
            tick(32 << p);
            bus(1'b0, T16BA_OFS_CONTROL, 8'h00);
            tick(64);
            bus(1'b1, T16BA_OFS_LOW, 8'h00);
            check({15'h0, q >= 8'd7 && q <= 8'd9}, 16'h1);
        end
        $display("test prescale done");
        bus(1'b0, T16BA_OFS_HIGH, 8'hFF);
        bus(1'b0, T16BA_OFS_LOW, 8'hFE);
        bus(1'b0, T16BA_OFS_CONTROL, 8'h01);
        tick(16);
        bus(1'b0, T16BA_OFS_CONTROL, 8'h00);
        rdchk(T16BA_OFS_HIGH, 8'h00);
        rdchk(T16BA_OFS_IRQ, 8'h01);
        check({15'h0, irq}, 16'h0);
        bus(1'b0, T16BA_OFS_IRQ, 8'h03);
        check({15'h0, irq}, 16'h1);
        bus(1'b0, T16BA_OFS_IRQ, 8'h02);
        rdchk(T16BA_OFS_IRQ, 8'h02);
        check({15'h0, irq}, 16'h0);
        $display("test overflow done");
        bus(1'b0, T16BA_OFS_LOW, 8'h40);
        adce <= 1'b1;
        mode <= 4'hA;
        match <= 1'b1;
        tick(2);
        check({15'h0, adcs}, 16'h0);
        match <= 1'b0;
        rdchk(T16BA_OFS_LOW, 8'h40);
        mode <= 4'hB;
        match <= 1'b1;
        tick(1);
        match <= 1'b0;
        tick(1);
        check({15'h0, adcs}, 16'h1);
        tick(1);
        rdchk(T16BA_OFS_LOW, 8'h00);
        rdchk(T16BA_OFS_IRQ, 8'h02);
        match <= 1'b1;
        fork
            bus(1'b0, T16BA_OFS_LOW, 8'h77);
            begin
                tick(2);
                match <= 1'b0;
            end
        join
        tick(1);
        rdchk(T16BA_OFS_LOW, 8'h77);
        $display("test trigger done");
        // pin keeps pulsing in crystal mode to show it is ignored then
        slp <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            bus(1'b0, T16BA_OFS_LOW, 8'h00);
            bus(1'b0, T16BA_OFS_CONTROL, codes[i]);
            pin_run <= 1'b1;
            tick(200);
            pin_run <= 1'b0;
            tick(24);
            bus(1'b0, T16BA_OFS_CONTROL, 8'h00);
            bus(1'b1, T16BA_OFS_LOW, 8'h00);
            if (i < 2)
                check({8'h0, q}, {8'h0, edges[7:0]});
            else
                check({15'h0, q >= 8'd4 && q <= 8'd6}, 16'h1);
        end
        $display("test external done");
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
